// File: design/sarseq_top.sv
// Sequencer and compare logic of a 10-bit successive-approximation converter
// Notes on behaviour
// - Sample window never shorter than two converter clocks.
// - Sample window never longer than fifteen converter clocks.
// - Conversion lasts twelve converter clocks plus sample window.
// - Pin enable bits 7..2 route pins to converter; bits 1..0 unused.
// - Ten-bit value split: upper eight at 0x97, lowest two at 0x96.
// - Result registers written by software, and by hardware only when a normal-mode conversion completes.
// - With compare enabled, result pair holds the threshold.
// - Interrupt request raised when flag set and interrupt enabled.
// - Compare mode sets flag when value strictly exceeds threshold.
// - Compare mode repeats until software clears start bit.
// - Nominal sample window is field plus one converter clocks.
// - Converter clock is 2,4,6,8,12,16,24 or 32 system clocks.
// - Normal mode clears start bit at end; software clear aborts.
// - Channel select codes 010..111 pick inputs two to seven.
`timescale 1ns/100ps
module sarseq_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [9:0]                 core_value,
    output sarseq_pkg::sarseq_core_ctl_t    core_ctl,
    output logic                            converter_irq
);
    import sarseq_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic          converter_enable_q, converter_enable_d;
    logic          converter_irq_flag_q, converter_irq_flag_d;
    logic          compare_enable_q, compare_enable_d;
    logic          irq_enable_q, irq_enable_d;
    logic          go_q, go_d;
    logic [2:0]    channel_select_field_q, channel_select_field_d;
    logic [2:0]    conv_clock_period_field_q, conv_clock_period_field_d;
    logic [3:0]    sample_time_field_q, sample_time_field_d;
    logic [5:0]    pin_analog_select_q, pin_analog_select_d;
    logic [9:0]    result_value_bits_q, result_value_bits_d;
    sarseq_state_t state_q, state_d;
    logic [3:0]    tad_cnt_q, tad_cnt_d;
    logic          converter_irq_q, converter_irq_d;
    sarseq_core_ctl_t core_ctl_q, core_ctl_d;

    logic          wr_en;
    logic          rd_en;
    logic          tick;
    logic          run;
    logic          done;
    logic [3:0]    window;
    logic [4:0]    nominal;
    logic [9:0]    core_sync1_q, core_sync2_q;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign run     = (state_q != SARSEQ_IDLE);

    // ****************************************
    // Analog value synchroniser
    // ****************************************
    // Bitwise sync is safe only because the core holds its value through a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sync1_q <= 10'h000;
            core_sync2_q <= 10'h000;
        end else begin
            core_sync1_q <= core_value;
            core_sync2_q <= core_sync1_q;
        end
    end

    sarseq_tick u_tick (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .run                     (run),
        .conv_clock_period_field (conv_clock_period_field_q),
        .tick                    (tick)
    );

    // ****************************************
    // Sample window
    // ****************************************
    always_comb begin
        nominal = {1'b0, sample_time_field_q} + 5'h01;
        if (nominal < {1'b0, SARSEQ_SAMPLE_MIN}) begin
            window = SARSEQ_SAMPLE_MIN;
        end else if (nominal > {1'b0, SARSEQ_SAMPLE_MAX}) begin
            window = SARSEQ_SAMPLE_MAX;
        end else begin
            window = nominal[3:0];
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_comb begin
        state_d   = state_q;
        tad_cnt_d = tad_cnt_q;
        done      = 1'b0;
        case (state_q)
            SARSEQ_IDLE: begin
                tad_cnt_d = 4'h0;
                if (go_q && converter_enable_q) begin
                    state_d = SARSEQ_SAMPLE;
                end
            end
            SARSEQ_SAMPLE: begin
                if (tick) begin
                    if (tad_cnt_q == window - 4'h1) begin
                        tad_cnt_d = 4'h0;
                        state_d   = SARSEQ_CONVERT;
                    end else begin
                        tad_cnt_d = tad_cnt_q + 4'h1;
                    end
                end
            end
            SARSEQ_CONVERT: begin
                if (tick) begin
                    if (tad_cnt_q == SARSEQ_CONV_TADS - 4'h1) begin
                        tad_cnt_d = 4'h0;
                        done      = 1'b1;
                        state_d   = SARSEQ_IDLE;
                    end else begin
                        tad_cnt_d = tad_cnt_q + 4'h1;
                    end
                end
            end
            default: begin
                state_d = SARSEQ_IDLE;
            end
        endcase
        if (!go_q || !converter_enable_q) begin
            state_d   = SARSEQ_IDLE;
            tad_cnt_d = 4'h0;
            done      = 1'b0;
        end
    end

    // ****************************************
    // Register file with hardware updates
    // ****************************************
    always_comb begin
        converter_enable_d        = converter_enable_q;
        converter_irq_flag_d      = converter_irq_flag_q;
        compare_enable_d          = compare_enable_q;
        irq_enable_d              = irq_enable_q;
        go_d                      = go_q;
        channel_select_field_d    = channel_select_field_q;
        conv_clock_period_field_d = conv_clock_period_field_q;
        sample_time_field_d       = sample_time_field_q;
        pin_analog_select_d       = pin_analog_select_q;
        result_value_bits_d       = result_value_bits_q;
        if (wr_en) begin
            case (paddr)
                SARSEQ_CTRL_OFF: begin
                    converter_enable_d     = pwdata[SARSEQ_CTRL_EN_BIT];
                    converter_irq_flag_d   = pwdata[SARSEQ_CTRL_IRQF_BIT];
                    compare_enable_d       = pwdata[SARSEQ_CTRL_CMP_BIT];
                    irq_enable_d           = pwdata[SARSEQ_CTRL_IRQEN_BIT];
                    channel_select_field_d = pwdata[SARSEQ_CTRL_CH_LSB +: 3];
                    go_d                   = pwdata[SARSEQ_CTRL_GO_BIT];
                end
                SARSEQ_TIMING_OFF: begin
                    conv_clock_period_field_d = pwdata[SARSEQ_TIM_CLK_LSB +: 3];
                    sample_time_field_d       = pwdata[SARSEQ_TIM_TS_LSB +: 4];
                end
                SARSEQ_PINEN_OFF: pin_analog_select_d = pwdata[SARSEQ_PINEN_LSB +: 6];
                SARSEQ_RESLO_OFF: result_value_bits_d[1:0] = pwdata[1:0];
                SARSEQ_RESHI_OFF: result_value_bits_d[9:2] = pwdata[7:0];
                default: ;
            endcase
        end
        // Hardware events placed after writes so they win over a write in the same cycle
        if (done) begin
            if (compare_enable_q) begin
                if (sample_q_next_gt(core_sync2_q, result_value_bits_q)) begin
                    converter_irq_flag_d = 1'b1;
                end
            end else begin
                result_value_bits_d  = core_sync2_q;
                converter_irq_flag_d = 1'b1;
                go_d                 = 1'b0;
            end
        end
    end

    function automatic logic sample_q_next_gt(input logic [9:0] v, input logic [9:0] thr);
        return v > thr;
    endfunction : sample_q_next_gt

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable_q        <= 1'b0;
            converter_irq_flag_q      <= 1'b0;
            compare_enable_q          <= 1'b0;
            irq_enable_q              <= 1'b0;
            go_q                      <= 1'b0;
            channel_select_field_q    <= SARSEQ_CH_RST;
            conv_clock_period_field_q <= SARSEQ_CLK_RST;
            sample_time_field_q       <= SARSEQ_TS_RST;
            pin_analog_select_q       <= SARSEQ_PINEN_RST[7:2];
            result_value_bits_q       <= SARSEQ_RESULT_RST;
            state_q                   <= SARSEQ_IDLE;
            tad_cnt_q                 <= 4'h0;
        end else begin
            converter_enable_q        <= converter_enable_d;
            converter_irq_flag_q      <= converter_irq_flag_d;
            compare_enable_q          <= compare_enable_d;
            irq_enable_q              <= irq_enable_d;
            go_q                      <= go_d;
            channel_select_field_q    <= channel_select_field_d;
            conv_clock_period_field_q <= conv_clock_period_field_d;
            sample_time_field_q       <= sample_time_field_d;
            pin_analog_select_q       <= pin_analog_select_d;
            result_value_bits_q       <= result_value_bits_d;
            state_q                   <= state_d;
            tad_cnt_q                 <= tad_cnt_d;
        end
    end

    // ****************************************
    // Read mux and outputs
    // ****************************************
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                SARSEQ_CTRL_OFF: begin
                    prdata[SARSEQ_CTRL_EN_BIT]    = converter_enable_q;
                    prdata[SARSEQ_CTRL_IRQF_BIT]  = converter_irq_flag_q;
                    prdata[SARSEQ_CTRL_CMP_BIT]   = compare_enable_q;
                    // Unused bit reads one as at reset
                    prdata[SARSEQ_CTRL_FIX_BIT]   = 1'b1;
                    prdata[SARSEQ_CTRL_CH_LSB +: 3] = channel_select_field_q;
                    prdata[SARSEQ_CTRL_GO_BIT]    = go_q;
                    prdata[SARSEQ_CTRL_IRQEN_BIT] = irq_enable_q;
                end
                SARSEQ_TIMING_OFF: begin
                    prdata[SARSEQ_TIM_CLK_LSB +: 3] = conv_clock_period_field_q;
                    prdata[SARSEQ_TIM_TS_LSB +: 4]  = sample_time_field_q;
                end
                SARSEQ_PINEN_OFF: prdata[SARSEQ_PINEN_LSB +: 6] = pin_analog_select_q;
                SARSEQ_RESLO_OFF: prdata[1:0] = result_value_bits_q[1:0];
                SARSEQ_RESHI_OFF: prdata[7:0] = result_value_bits_q[9:2];
                default: ;
            endcase
        end
    end

    // Built from next values, so the flops add no cycle of lag
    always_comb begin
        converter_irq_d              = converter_irq_flag_d && irq_enable_d;
        core_ctl_d.channel           = channel_select_field_d;
        core_ctl_d.sample            = (state_d == SARSEQ_SAMPLE);
        core_ctl_d.convert           = (state_d == SARSEQ_CONVERT);
        core_ctl_d.pin_analog_select = pin_analog_select_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_irq_q <= 1'b0;
            core_ctl_q      <= 11'h000;
        end else begin
            converter_irq_q <= converter_irq_d;
            core_ctl_q      <= core_ctl_d;
        end
    end

    assign converter_irq = converter_irq_q;
    assign core_ctl      = core_ctl_q;

endmodule : sarseq_top

// File: design/sarseq_pkg.sv
// Package with register map, field layout and timing constants of the converter sequencer
package sarseq_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] SARSEQ_CTRL_OFF   = 8'h93;
    localparam logic [7:0] SARSEQ_TIMING_OFF = 8'h94;
    localparam logic [7:0] SARSEQ_PINEN_OFF  = 8'h95;
    localparam logic [7:0] SARSEQ_RESLO_OFF  = 8'h96;
    localparam logic [7:0] SARSEQ_RESHI_OFF  = 8'h97;

    // ****************************************
    // Control, timing and pin enable register fields
    // ****************************************
    localparam int SARSEQ_CTRL_EN_BIT    = 7;
    localparam int SARSEQ_CTRL_IRQF_BIT  = 6;
    localparam int SARSEQ_CTRL_CMP_BIT   = 5;
    localparam int SARSEQ_CTRL_FIX_BIT   = 4;
    localparam int SARSEQ_CTRL_CH_LSB    = 1;
    localparam int SARSEQ_CTRL_GO_BIT    = 0;
    localparam int SARSEQ_CTRL_IRQEN_BIT = 8;
    localparam int SARSEQ_TIM_CLK_LSB    = 5;
    localparam int SARSEQ_TIM_TS_LSB     = 0;
    localparam int SARSEQ_PINEN_LSB      = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] SARSEQ_PINEN_RST  = 8'h00;
    localparam logic [9:0] SARSEQ_RESULT_RST = 10'h000;
    localparam logic [3:0] SARSEQ_TS_RST     = 4'h0;
    localparam logic [2:0] SARSEQ_CLK_RST    = 3'h0;
    localparam logic [2:0] SARSEQ_CH_RST     = 3'h0;

    // ****************************************
    // Timing counts in converter clock periods
    // ****************************************
    localparam logic [3:0] SARSEQ_SAMPLE_MIN = 4'h2;
    localparam logic [3:0] SARSEQ_SAMPLE_MAX = 4'hF;
    localparam logic [3:0] SARSEQ_CONV_TADS  = 4'hC;

    typedef enum logic [1:0] {
        SARSEQ_IDLE,
        SARSEQ_SAMPLE,
        SARSEQ_CONVERT
    } sarseq_state_t;

    // Analog core handshake towards the converter core
    typedef struct packed {
        logic       sample;
        logic       convert;
        logic [2:0] channel;
        logic [5:0] pin_analog_select;
    } sarseq_core_ctl_t;

endpackage : sarseq_pkg

// File: design/sarseq_tick.sv
// Converter clock tick generator dividing the system clock
`timescale 1ns/100ps
module sarseq_tick (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [2:0] conv_clock_period_field,
    output logic            tick
);
    import sarseq_pkg::*;

    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] period;

    always_comb begin
        case (conv_clock_period_field)
            3'h0:    period = 6'h02;
            3'h1:    period = 6'h04;
            3'h2:    period = 6'h06;
            3'h3:    period = 6'h08;
            3'h4:    period = 6'h0C;
            3'h5:    period = 6'h10;
            3'h6:    period = 6'h18;
            default: period = 6'h20;
        endcase
    end

    always_comb begin
        tick  = 1'b0;
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = 6'h00;
        end else if (cnt_q >= period - 6'h01) begin
            cnt_d = 6'h00;
            tick  = 1'b1;
        end else begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : sarseq_tick

// File: tb/sarseq_top_sva.sv
// Assertion checker on the ports of the converter sequencer
`timescale 1ns/100ps
module sarseq_top_sva (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [7:0]                   paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic [9:0]                   core_value,
    input wire sarseq_pkg::sarseq_core_ctl_t core_ctl,
    input wire logic                         converter_irq
);
    import sarseq_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Run-length counters of the two phases
    // ****************************************
    logic       acc_w;
    logic       acc_r;
    logic [9:0] samp_cnt_q;
    logic [9:0] samp_cnt_d;
    logic [9:0] conv_cnt_q;
    logic [9:0] conv_cnt_d;
    assign acc_w = psel && penable && pwrite;
    assign acc_r = psel && penable && !pwrite;
    always_comb begin
        samp_cnt_d = core_ctl.sample ? samp_cnt_q + 10'h001 : 10'h000;
        conv_cnt_d = core_ctl.convert ? conv_cnt_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt_q <= 10'h000;
            conv_cnt_q <= 10'h000;
        end else begin
            samp_cnt_q <= samp_cnt_d;
            conv_cnt_q <= conv_cnt_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_sample_min_len: assert property ($rose(core_ctl.sample) |-> core_ctl.sample[*4])
        else $error("sample window shorter than two converter clocks");
    a_sample_max_len: assert property (samp_cnt_q <= 10'h1E0)
        else $error("sample window longer than fifteen slowest converter clocks");
    a_convert_max_len: assert property (conv_cnt_q <= 10'h180)
        else $error("convert phase longer than twelve slowest converter clocks");
    a_sample_then_conv: assert property ($fell(core_ctl.sample) && !$past(acc_w, 2) |-> core_ctl.convert)
        else $error("sample window not followed by convert phase");
    a_stop_on_clear: assert property (acc_w && paddr == SARSEQ_CTRL_OFF && !(pwdata[7] && pwdata[0])
        |=> ##1 !core_ctl.sample && !core_ctl.convert)
        else $error("conversion not stopped by clearing start or enable");
    a_pin_route: assert property (acc_w && paddr == SARSEQ_PINEN_OFF
        |=> core_ctl.pin_analog_select == $past(pwdata[7:2]))
        else $error("pin enable bits not routed");
    a_channel_route: assert property (acc_w && paddr == SARSEQ_CTRL_OFF |=> core_ctl.channel == $past(pwdata[3:1]))
        else $error("channel select not routed");
    a_irq_level: assert property (acc_r && paddr == SARSEQ_CTRL_OFF |-> converter_irq == (prdata[6] && prdata[8]))
        else $error("interrupt request differs from flag and enable");
    a_pinen_unused: assert property (acc_r && paddr == SARSEQ_PINEN_OFF |-> prdata[1:0] == 2'h0)
        else $error("unused pin enable bits read nonzero");
    a_zero_wait: assert property (pready && !pslverr)
        else $error("slave inserted wait or error");
    c_conv_done: cover property ($fell(core_ctl.convert));
    c_irq_raised: cover property ($rose(converter_irq));
    c_thr_write: cover property (acc_w && paddr == SARSEQ_RESHI_OFF);
endmodule : sarseq_top_sva

bind sarseq_top sarseq_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_value(core_value), .core_ctl(core_ctl), .converter_irq(converter_irq));

// File: tb/sarseq_core_model.sv
// Behavioural model of the converter core, passing one input level with no channel selection
`timescale 1ns/100ps
module sarseq_core_model (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire sarseq_pkg::sarseq_core_ctl_t core_ctl,
    input  wire logic [9:0]                   level,
    output logic      [9:0]                   core_value
);
    import sarseq_pkg::*;
    logic [9:0] value_q;
    logic [9:0] value_d;
    // Outside a frame the value toggles so stale data never looks valid
    always_comb begin
        value_d = (core_ctl.sample || core_ctl.convert) ? level : ~value_q;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= 10'h000;
        end else begin
            value_q <= value_d;
        end
    end
    assign core_value = value_q;
endmodule : sarseq_core_model

// File: tb/tb.sv
// Self-checking testbench of the converter sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
    import sarseq_pkg::*;
    logic             pclk    = 1'b0;
    logic             presetn = 1'b0;
    logic             psel    = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite  = 1'b0;
    logic [7:0]       paddr   = 8'h00;
    logic [31:0]      pwdata  = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic [9:0]       level   = 10'h000;
    logic [9:0]       core_value;
    logic             converter_irq;
    sarseq_core_ctl_t core_ctl;
    int               errors = 0;
    int               check_count = 0;
    int               s_cnt = 0;
    int               c_cnt = 0;
    int               tad_tab[8] = '{2, 4, 6, 8, 12, 16, 24, 32};

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (core_ctl.sample === 1'b1) s_cnt <= s_cnt + 1;
        if (core_ctl.convert === 1'b1) c_cnt <= c_cnt + 1;
    end

    sarseq_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .core_value(core_value), .core_ctl(core_ctl), .converter_irq(converter_irq));
    sarseq_core_model u_core (.pclk(pclk), .presetn(presetn), .core_ctl(core_ctl), .level(level),
        .core_value(core_value));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, d, dummy);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d);
    endtask : rd

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] r;
        rd(SARSEQ_CTRL_OFF, r);   `CHK(r, 32'h10)
        rd(SARSEQ_TIMING_OFF, r); `CHK(r, 32'h0)
        rd(SARSEQ_PINEN_OFF, r);  `CHK(r, 32'h0)
        rd(SARSEQ_RESLO_OFF, r);  `CHK(r, 32'h0)
        rd(SARSEQ_RESHI_OFF, r);  `CHK(r, 32'h0)
        wr(8'h40, 32'hFF); rd(8'h40, r); `CHK(r, 32'h0)
        wr(SARSEQ_PINEN_OFF, 32'hFF); rd(SARSEQ_PINEN_OFF, r); `CHK(r, 32'hFC)
        `CHK(core_ctl.pin_analog_select, 6'h3F)
        wr(SARSEQ_RESLO_OFF, 32'hFF); rd(SARSEQ_RESLO_OFF, r); `CHK(r, 32'h03)
    endtask : t_regs

    task automatic conv_run(input logic [2:0] tadc, input logic [3:0] ts, input logic [2:0] ch, input logic [9:0] v);
        logic [31:0] r;
        int          tad, w, s0, c0, n;
        tad = tad_tab[tadc];
        w = (ts + 1 < 2) ? 2 : ((ts + 1 > 15) ? 15 : ts + 1);
        level <= v;
        wr(SARSEQ_TIMING_OFF, {24'h0, tadc, 1'b0, ts});
        s0 = s_cnt; c0 = c_cnt;
        wr(SARSEQ_CTRL_OFF, 32'h180 | {28'h0, ch, 1'b0});
        wr(SARSEQ_CTRL_OFF, 32'h181 | {28'h0, ch, 1'b0});
        `CHK(core_ctl.channel, ch)
        n = 0; r = 32'h1;
        while (r[0] === 1'b1 && n < 2000) begin
            rd(SARSEQ_CTRL_OFF, r);
            n++;
        end
        `CHK(r[6:0], {1'b1, 1'b0, 1'b1, ch, 1'b0})
        `CHK(converter_irq, 1'b1)
        `CHK((s_cnt - s0 + tad / 2) / tad, w)
        `CHK((c_cnt - c0 + tad / 2) / tad, 12)
        rd(SARSEQ_RESHI_OFF, r); `CHK(r, {24'h0, v[9:2]})
        rd(SARSEQ_RESLO_OFF, r); `CHK(r, {30'h0, v[1:0]})
        wr(SARSEQ_CTRL_OFF, 32'h0); `CHK(converter_irq, 1'b0)
    endtask : conv_run

    task automatic t_abort();
        logic [31:0] r;
        wr(SARSEQ_RESHI_OFF, 32'h12); wr(SARSEQ_RESLO_OFF, 32'h3);
        wr(SARSEQ_TIMING_OFF, 32'hEF);
        wr(SARSEQ_CTRL_OFF, 32'h85);
        repeat (40) @(posedge pclk);
        wr(SARSEQ_CTRL_OFF, 32'h84);
        @(posedge pclk);
        `CHK({core_ctl.sample, core_ctl.convert}, 2'b00)
        repeat (100) @(posedge pclk);
        rd(SARSEQ_CTRL_OFF, r); `CHK(r[6:0], 7'h14)
        rd(SARSEQ_RESHI_OFF, r); `CHK(r, 32'h12)
    endtask : t_abort

    task automatic t_compare();
        logic [31:0] r;
        int          c0;
        level <= 10'h200;
        wr(SARSEQ_RESHI_OFF, 32'h80); wr(SARSEQ_RESLO_OFF, 32'h0);
        wr(SARSEQ_TIMING_OFF, 32'h0); wr(SARSEQ_CTRL_OFF, 32'h20);
        c0 = c_cnt;
        wr(SARSEQ_CTRL_OFF, 32'h1A5);
        repeat (200) @(posedge pclk);
        rd(SARSEQ_CTRL_OFF, r); `CHK(r[6:0], 7'h35)
        `CHK((c_cnt - c0) > 100, 1'b1)
        rd(SARSEQ_RESHI_OFF, r); `CHK(r, 32'h80)
        level <= 10'h201;
        repeat (100) @(posedge pclk);
        rd(SARSEQ_CTRL_OFF, r); `CHK(r[6:0], 7'h75)
        `CHK(converter_irq, 1'b1)
        rd(SARSEQ_RESHI_OFF, r); `CHK(r, 32'h80)
        rd(SARSEQ_RESLO_OFF, r); `CHK(r, 32'h0)
        wr(SARSEQ_CTRL_OFF, 32'h0);
        repeat (10) @(posedge pclk);
        `CHK({core_ctl.sample, core_ctl.convert, converter_irq}, 3'b000)
    endtask : t_compare

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        for (int i = 0; i < 8; i++) begin
            conv_run(3'(i), (i == 7) ? 4'hF : 4'(i * 2), 3'(2 + i % 6), 10'(16'h0155 + i * 16'h0049));
        end
        t_abort();
        t_compare();
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        wrap_up();
    end
endmodule : tb
